// >>> strap_latch_defs.vh
`ifndef STRAP_LATCH_DEFS_VH
`define STRAP_LATCH_DEFS_VH

// ************************************************************
// register map, byte addresses on the 6-bit bus
// ************************************************************
`define REG_CTRL        6'h00
`define REG_PORT_STRAP  6'h04
`define REG_LEVELS      6'h08
`define REG_STATUS      6'h0C
`define REG_MUX_SEL     6'h10
`define REG_MUX_FN      6'h14

// ************************************************************
// strap resistor level codes (sensed by analog front end)
// ************************************************************
`define LVL_200K_DN     3'h0
`define LVL_200K_UP     3'h1
`define LVL_10K_DN      3'h2
`define LVL_10K_UP      3'h3
`define LVL_10R_DN      3'h4
`define LVL_10R_UP      3'h5

// ************************************************************
// pin function codes
// ************************************************************
`define FN_NONE         5'h00
`define FN_AUD_DIN      5'h01
`define FN_AUD_DOUT     5'h02
`define FN_AUD_BCLK     5'h03
`define FN_AUD_WSEL     5'h04
`define FN_AUD_MCLK     5'h05
`define FN_SS_PWR3      5'h06
`define FN_SS_PWR4      5'h07
`define FN_SS_PWR5      5'h08
`define FN_PWR1         5'h09
`define FN_PWR2         5'h0A
`define FN_PWR3         5'h0B
`define FN_PWR4         5'h0C
`define FN_PWR5         5'h0D
`define FN_PWR6         5'h0E
`define FN_HOST_SCL     5'h0F
`define FN_MICROPHONE_DETECT      5'h10
`define FN_SPI_CE       5'h11
`define FN_SPI_CLK      5'h12
`define FN_SPI_D0       5'h13
`define FN_SPI_D1       5'h14
`define FN_SPI_D2       5'h15
`define FN_SPI_D3       5'h16
`define FN_TGT_SCL      5'h17
`define FN_TGT_SDA      5'h18
`define FN_GPIO         5'h19
`define FN_BUS_POWER_DETECT     5'h1A
`define FN_HOST_SDA     5'h1B
`define FN_RESERVED     5'h1F

`define PIN_FIRST       3
`define PIN_LAST        31
`define PIN_COUNT       29

`endif

// >>> ladder_decode.v
`include "strap_latch_defs.vh"

// ************************************************************
// resistor level to thermometer port mask
// ************************************************************
module ladder_decode (
  input  wire [2:0] level_i,   // captured level code
  output reg  [5:0] mask_o     // ports 6..1 selected
);

  // unknown codes fall back to no ports, the safe side
  always @*
  begin
    case (level_i)
      `LVL_200K_DN: mask_o = 6'h00;
      `LVL_200K_UP: mask_o = 6'h01;
      `LVL_10K_DN:  mask_o = 6'h03;
      `LVL_10K_UP:  mask_o = 6'h07;
      `LVL_10R_DN:  mask_o = 6'h0F;
      `LVL_10R_UP:  mask_o = 6'h3F;
      default:      mask_o = 6'h00;
    endcase
  end

endmodule

// >>> default_pin_map.v
`include "strap_latch_defs.vh"

// ************************************************************
// configuration 3 default function per programmable pin
// ************************************************************
module default_pin_map (
  input  wire       cfg_ok_i,   // mode straps hold configuration 3
  input  wire [4:0] pin_i,      // pin number 3..31
  output reg  [4:0] func_o      // default function code
);

  // table lookup; reserved mode leaves every pin unassigned
  always @*
  begin
    func_o = `FN_NONE;
    if (cfg_ok_i)
    begin
      case (pin_i)
        5'd3:  func_o = `FN_AUD_DIN;     // [R13]
        5'd4:  func_o = `FN_AUD_DOUT;
        5'd5:  func_o = `FN_AUD_BCLK;
        5'd6:  func_o = `FN_AUD_WSEL;
        5'd7:  func_o = `FN_AUD_MCLK;
        5'd10: func_o = `FN_SS_PWR3;
        5'd11: func_o = `FN_SS_PWR4;
        5'd12: func_o = `FN_SS_PWR5;
        5'd13: func_o = `FN_PWR5;
        5'd14: func_o = `FN_PWR4;
        5'd15: func_o = `FN_PWR3;
        5'd16: func_o = `FN_PWR2;
        5'd17: func_o = `FN_PWR1;
        5'd18: func_o = `FN_HOST_SCL;    // [R14]
        5'd19: func_o = `FN_MICROPHONE_DETECT;
        5'd20: func_o = `FN_SPI_CE;
        5'd21: func_o = `FN_SPI_CLK;
        5'd22: func_o = `FN_SPI_D0;
        5'd23: func_o = `FN_SPI_D1;
        5'd24: func_o = `FN_SPI_D2;
        5'd25: func_o = `FN_SPI_D3;
        5'd26: func_o = `FN_TGT_SCL;
        5'd27: func_o = `FN_TGT_SDA;
        5'd28: func_o = `FN_PWR6;
        5'd29: func_o = `FN_GPIO;
        5'd30: func_o = `FN_BUS_POWER_DETECT;
        5'd31: func_o = `FN_HOST_SDA;
        default: func_o = `FN_NONE;
      endcase
    end
  end

endmodule

// >>> strap_latch.v
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`include "strap_latch_defs.vh"

// What this block does
// R1 - capture all straps at power-on reset end and external reset release
// R2 - after capture, strap pins return to their programmable function
// R3 - plus-line strap: 0 line enabled, 1 line disabled, ports 1 to 6
// R4 - minus-line strap: 0 line enabled, 1 line disabled, ports 1 to 6
// R5 - port disabled only when both its line straps were captured high
// R6 - a strap-disabled port also loses its superspeed path
// R7 - fixed-port strap level gives 0,1,2,3,4 or 6 non-removable ports
// R8 - charge strap level gives charging on 0,1,2,3,4 or 6 ports
// R9 - mode straps 2 and 1 at 200k down and 10k down select configuration 3
// R10 - board uses no other mode strap encoding; others are reserved
// R11 - board pulls the third mode strap down through 200k
// R12 - 29 programmable pins, numbered 3 to 31, each with a default function
// R13 - configuration 3 maps pins 3 to 17 to audio and power controls; pins 8 and 9 get FN_NONE
// R14 - configuration 3 maps pins 18 to 31 to i2c, spi, detect, power and io
// R15 - software can override any pin function through the pin-mux registers
// R16 - board holds straps valid before the capture point
// R17 - external reset is active low; its release triggers capture
// R18 - captured values stay constant between captures, given as decoded fields
module strap_latch (
  input  wire        sys_clk_i,                     // core clock, 40 MHz
  input  wire        resetn_i,                      // async power-on reset, low
  input  wire        ext_resetn_i,                  // external chip reset, low
  input  wire [5:0]  port_plus_line_off_strap_i,    // plus-line straps, ports 6..1
  input  wire [5:0]  port_minus_line_off_strap_i,   // minus-line straps, ports 6..1
  input  wire [2:0]  fixed_port_count_strap_i,      // sensed level code
  input  wire [2:0]  charge_port_count_strap_i,     // sensed level code
  input  wire [2:0]  mode_strap2_i,                 // sensed level code
  input  wire [2:0]  mode_strap1_i,                 // sensed level code
  input  wire [5:0]  avs_address_i,                 // byte address
  input  wire        avs_read_i,                    // read request
  input  wire        avs_write_i,                   // write request
  input  wire [31:0] avs_writedata_i,               // write data
  input  wire [3:0]  avs_byteenable_i,              // byte lanes
  output wire        avs_waitrequest_o,             // stall
  output reg  [31:0] avs_readdata_o,                // read data
  output wire        avs_response_err_o,            // unmapped access flag
  output wire        strap_sample_o,                // pins held as straps
  output reg  [5:0]  port_disable_o,                // hs port off, ports 6..1
  output reg  [5:0]  ss_port_disable_o,             // superspeed port off
  output reg  [5:0]  fixed_port_mask_o,             // non-removable ports
  output reg  [5:0]  charge_port_mask_o,            // charging ports
  output reg         mode_reserved_o,               // mode straps not config 3
  output reg  [144:0] pin_func_o                    // 29 x 5-bit function codes
);

  // ************************************************************
  // reset sequencing and capture
  // ************************************************************
  localparam ST_HOLD = 3'b001;
  localparam ST_CAPT = 3'b010;
  localparam ST_RUN  = 3'b100;

  // sequencer, captured strap images and bus-side state
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [5:0]  cap_plus;
  reg  [5:0]  cap_minus;
  reg  [2:0]  cap_fixed;
  reg  [2:0]  cap_charge;
  reg  [2:0]  cap_mode2;
  reg  [2:0]  cap_mode1;
  reg  [7:0]  capture_count;
  reg  [28:0] override_en;
  reg  [4:0]  mux_sel;
  reg         read_pending;
  wire [5:0]  fixed_mask;
  wire [5:0]  charge_mask;
  wire        cfg_ok;
  wire [4:0]  sel_default;

  // after any reset ends: hold, one capture cycle, then run
  // the capture cycle still has the pins in strap mode, so the board
  // level is what lands even though the pins turn into functions next
  // hold while any reset is low; sample on the second edge after release
  always @*
  begin
    case (state)
      ST_HOLD: next_state = ext_resetn_i ? ST_CAPT : ST_HOLD;  // [R17]
      ST_CAPT: next_state = ST_RUN;
      ST_RUN:  next_state = ext_resetn_i ? ST_RUN : ST_HOLD;
      default: next_state = ST_HOLD;
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  // pins act as straps until the capture, then go to their function
  assign strap_sample_o = (state != ST_RUN);  // [R2]

  // capture is clocked, never in the async branch; held until next capture
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cap_plus      <= 6'h00;
      cap_minus     <= 6'h00;
      cap_fixed     <= `LVL_200K_DN;
      cap_charge    <= `LVL_200K_DN;
      cap_mode2     <= `LVL_200K_DN;
      cap_mode1     <= `LVL_10K_DN;
      capture_count <= 8'h00;
    end
    else if (state == ST_CAPT)
    begin
      cap_plus      <= port_plus_line_off_strap_i;   // [R1]
      cap_minus     <= port_minus_line_off_strap_i;  // [R1]
      cap_fixed     <= fixed_port_count_strap_i;     // [R1]
      cap_charge    <= charge_port_count_strap_i;    // [R1]
      cap_mode2     <= mode_strap2_i;                // [R1]
      cap_mode1     <= mode_strap1_i;                // [R1]
      capture_count <= capture_count + 8'h01;
    end
  end

  // ************************************************************
  // decoders
  // ************************************************************
  // both ladders share one shape: level code to a thermometer port mask
  // out-of-range codes give no ports rather than a guessed count
  ladder_decode u_fixed_dec (
    .level_i (cap_fixed),
    .mask_o  (fixed_mask)     // [R7]
  );

  ladder_decode u_charge_dec (
    .level_i (cap_charge),
    .mask_o  (charge_mask)    // [R8]
  );

  // only one legal mode encoding; anything else flagged reserved
  assign cfg_ok = (cap_mode2 == `LVL_200K_DN) && (cap_mode1 == `LVL_10K_DN);  // [R9]

  default_pin_map u_sel_map (
    .cfg_ok_i (cfg_ok),
    .pin_i    (mux_sel),
    .func_o   (sel_default)
  );

  // registered decoded fields, stable between captures
  // a flop stage so consumers never see a half-updated capture
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      port_disable_o     <= 6'h00;
      ss_port_disable_o  <= 6'h00;
      fixed_port_mask_o  <= 6'h00;
      charge_port_mask_o <= 6'h00;
      mode_reserved_o    <= 1'b0;
    end
    else
    begin
      port_disable_o     <= cap_plus & cap_minus;    // [R3] [R4] [R5] [R18]
      ss_port_disable_o  <= cap_plus & cap_minus;    // [R6]
      fixed_port_mask_o  <= fixed_mask;              // [R18]
      charge_port_mask_o <= charge_mask;             // [R18]
      mode_reserved_o    <= ~cfg_ok;
    end
  end

  // ************************************************************
  // pin-mux: defaults from strap, per-pin override
  // ************************************************************
  reg  [4:0]   override_func [0:28];
  wire [144:0] dflt_all;
  integer      k;
  genvar       g;

  // one table copy per pin, so every default is ready in the same cycle
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1)
    begin : g_pin
      localparam integer PIN_INT = g + `PIN_FIRST;
      localparam [4:0]   PIN_NUM = PIN_INT[4:0];   // pin numbers fit five bits
      default_pin_map u_map (
        .cfg_ok_i (cfg_ok),
        .pin_i    (PIN_NUM),                      // [R12]
        .func_o   (dflt_all[g*5 +: 5])
      );
    end
  endgenerate

  // an enabled override wins; clearing the enable restores the strap default
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pin_func_o <= {`PIN_COUNT{`FN_NONE}};
    else
    begin
      for (k = 0; k < `PIN_COUNT; k = k + 1)
      begin
        if (override_en[k])
          pin_func_o[k*5 +: 5] <= override_func[k];    // [R15]
        else
          pin_func_o[k*5 +: 5] <= dflt_all[k*5 +: 5];  // [R13] [R14]
      end
    end
  end

  // ************************************************************
  // avalon-mm slave, fixed one wait state on reads
  // ************************************************************
  // register map, 32-bit words on byte addresses:
  //   ctrl       read capture count [7:0]; write bit 0 set drops all overrides
  //   port_strap captured line straps {minus [11:6], plus [5:0]}
  //   levels     level codes {mode2, mode1, charge, fixed}, three bits each
  //   status     {mode reserved [24], charge [17:12], fixed [11:6], port off [5:0]}
  //   mux_sel    pin number 3..31 that mux_fn reaches, resets to 3
  //   mux_fn     override function [4:0] on write, strap default on read, and override enable [8] of the selected pin
  // a select below 3 reaches nothing: writes drop, reads show zero
  // unmapped addresses read zero and raise the error flag for that access
  wire        wr_hit_ctrl;
  wire        wr_hit_sel;
  wire        wr_hit_fn;
  wire        mapped;
  wire [4:0]  sel_idx;
  wire        sel_valid;

  // field bytes sit in lane 0, the override enable in lane 1
  assign wr_hit_ctrl = avs_write_i && (avs_address_i == `REG_CTRL);
  assign wr_hit_sel  = avs_write_i && (avs_address_i == `REG_MUX_SEL);
  assign wr_hit_fn   = avs_write_i && (avs_address_i == `REG_MUX_FN);
  assign mapped      = (avs_address_i == `REG_CTRL)    || (avs_address_i == `REG_PORT_STRAP) ||
                       (avs_address_i == `REG_LEVELS)  || (avs_address_i == `REG_STATUS)     ||
                       (avs_address_i == `REG_MUX_SEL) || (avs_address_i == `REG_MUX_FN);

  // the table index is the pin number minus three
  assign sel_idx     = mux_sel - 5'h03;
  assign sel_valid   = (mux_sel >= 5'h03);

  // reads stall one cycle so readdata comes from a flop
  assign avs_waitrequest_o  = avs_read_i && !read_pending;
  assign avs_response_err_o = (avs_read_i || avs_write_i) && !mapped;

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      read_pending <= 1'b0;
    else
      read_pending <= avs_read_i && !read_pending;
  end

  // writes: ctrl bit 0 drops every override back to strap defaults
  // ctrl and mux_fn never share a cycle, so clear and set cannot collide
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mux_sel     <= 5'd3;
      override_en <= 29'h0000_0000;
    end
    else
    begin
      if (wr_hit_sel && avs_byteenable_i[0])
        mux_sel <= avs_writedata_i[4:0];
      if (wr_hit_ctrl && avs_byteenable_i[0] && avs_writedata_i[0])
        override_en <= 29'h0000_0000;
      else if (wr_hit_fn && avs_byteenable_i[1] && sel_valid)
        override_en[sel_idx] <= avs_writedata_i[8];  // [R15]
    end
  end

  // override table; plain array, no reset needed as enables gate it
  always @(posedge sys_clk_i)
  begin
    if (wr_hit_fn && avs_byteenable_i[0] && sel_valid)
      override_func[sel_idx] <= avs_writedata_i[4:0];
  end

  // read mux, registered
  // loaded once per read, so the data stands until the next read
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !read_pending)
    begin
      case (avs_address_i)
        `REG_CTRL:       avs_readdata_o <= {24'h00_0000, capture_count};
        `REG_PORT_STRAP: avs_readdata_o <= {20'h0_0000, cap_minus, cap_plus};
        `REG_LEVELS:     avs_readdata_o <= {20'h0_0000, cap_mode2, cap_mode1,
                                   cap_charge, cap_fixed};
        `REG_STATUS:     avs_readdata_o <= {7'h00, mode_reserved_o, 6'h00,
                                  charge_port_mask_o, fixed_port_mask_o,
                                  port_disable_o};
        `REG_MUX_SEL:    avs_readdata_o <= {27'h000_0000, mux_sel};
        `REG_MUX_FN:     avs_readdata_o <= {16'h0000, 7'h00,
                                  (sel_valid ? override_en[sel_idx] : 1'b0),
                                  3'h0, sel_default};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> strap_latch_sva.sv
// ************************************************************
// strap capture checker
// ************************************************************
module strap_latch_sva (
  input wire       sys_clk_i,                   // core clock
  input wire       resetn_i,                    // power-on reset
  input wire       ext_resetn_i,                // external reset
  input wire [5:0] port_plus_line_off_strap_i,  // plus straps
  input wire [5:0] port_minus_line_off_strap_i, // minus straps
  input wire [2:0] fixed_port_count_strap_i,    // fixed level
  input wire       avs_read_i,                  // read
  input wire       avs_write_i,                 // write
  input wire       avs_waitrequest_o,           // stall
  input wire       strap_sample_o,              // strap phase
  input wire [5:0] port_disable_o,              // hs off
  input wire [5:0] ss_port_disable_o,           // ss off
  input wire [5:0] fixed_port_mask_o            // fixed mask
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [2:0] low_cnt;
  // ladder level to port mask, level 5 jumps to all six ports
  function [5:0] therm(input [2:0] l);
    therm = (l == 3'h5) ? 6'h3f : (6'h01 << l) - 6'h01;
  endfunction
  // cycles since release; outputs may still settle for three edges
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_cnt <= 3'h0;
    else if (strap_sample_o)
      low_cnt <= 3'h0;
    else if (low_cnt != 3'h4)
      low_cnt <= low_cnt + 3'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // capture edge lies two samples back at the end of this
  sequence capture_s;
    $fell(strap_sample_o) ##1 1'b1;
  endsequence
  both_lines_a: assert property (capture_s |-> port_disable_o ==
    ($past(port_plus_line_off_strap_i, 2) & $past(port_minus_line_off_strap_i, 2)))
    else $error("port off not both captured lines");
  fixed_mask_a: assert property (capture_s |->
    fixed_port_mask_o == therm($past(fixed_port_count_strap_i, 2)))
    else $error("fixed mask wrong");
  ss_follow_a: assert property (capture_s |-> ss_port_disable_o ==
    ($past(port_plus_line_off_strap_i, 2) & $past(port_minus_line_off_strap_i, 2)))
    else $error("ss off differs");
  hold_stable_a: assert property (low_cnt == 3'h4 |->
    $stable(port_disable_o) && $stable(fixed_port_mask_o)) else $error("fields moved");
  ext_hold_a: assert property ((!ext_resetn_i)[*2] |-> strap_sample_o)
    else $error("no strap phase in ext reset");
  pin_release_a: assert property ($rose(ext_resetn_i) |-> ##[1:4] !strap_sample_o)
    else $error("pins not released");
  read_wait_a: assert property ($rose(avs_read_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("read wait wrong");
  write_nowait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
endmodule
bind strap_latch strap_latch_sva u_sva (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ext_resetn_i(ext_resetn_i),
  .port_plus_line_off_strap_i(port_plus_line_off_strap_i),
  .port_minus_line_off_strap_i(port_minus_line_off_strap_i),
  .fixed_port_count_strap_i(fixed_port_count_strap_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .strap_sample_o(strap_sample_o), .port_disable_o(port_disable_o),
  .ss_port_disable_o(ss_port_disable_o), .fixed_port_mask_o(fixed_port_mask_o)
);

// >>> strap_board.sv
// ************************************************************
// board strap resistors
// ************************************************************
module strap_board (
  input  wire        hold_i, // device treats pins as straps
  input  wire [23:0] fit_i,  // fitted levels
  output wire [23:0] pin_o   // level seen at the pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // valid while sampled, function traffic afterwards, so a late capture sees junk
  // mode fields only carry config 3 unless the bench fits a reserved one
  // third mode strap is a fixed 200k pull-down, not wired to the block
  assign pin_o = hold_i ? fit_i : ~fit_i;
endmodule

// >>> tb_top.sv
`include "strap_latch_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  reg          sys_clk_i = 1'b0;
  reg          resetn_i = 1'b0;
  reg          ext_resetn_i = 1'b1;
  reg  [23:0]  fit = 24'h00_0090;
  reg  [5:0]   avs_address_i = 6'h00;
  reg          avs_read_i = 1'b0;
  reg          avs_write_i = 1'b0;
  reg  [31:0]  avs_writedata_i = 32'h0000_0000;
  wire [23:0]  pin;
  wire         avs_waitrequest_o, avs_response_err_o, strap_sample_o, mode_reserved_o;
  wire [31:0]  avs_readdata_o;
  wire [5:0]   port_disable_o, ss_port_disable_o, fixed_port_mask_o, charge_port_mask_o;
  wire [144:0] pin_func_o;
  int          err_total = 0;
  int          n_checks = 0;
  // ************************************************************
  // clock, board and device
  // ************************************************************
  always #12.5 sys_clk_i = ~sys_clk_i;
  strap_board u_board (.hold_i(strap_sample_o), .fit_i(fit), .pin_o(pin));
  strap_latch u_dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ext_resetn_i(ext_resetn_i),
    .port_plus_line_off_strap_i(pin[17:12]), .port_minus_line_off_strap_i(pin[23:18]),
    .fixed_port_count_strap_i(pin[2:0]), .charge_port_count_strap_i(pin[5:3]),
    .mode_strap2_i(pin[11:9]), .mode_strap1_i(pin[8:6]), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o), .avs_response_err_o(avs_response_err_o),
    .strap_sample_o(strap_sample_o), .port_disable_o(port_disable_o),
    .ss_port_disable_o(ss_port_disable_o), .fixed_port_mask_o(fixed_port_mask_o),
    .charge_port_mask_o(charge_port_mask_o), .mode_reserved_o(mode_reserved_o),
    .pin_func_o(pin_func_o));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input [144:0] got, input [144:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // one bus cycle: request right after an edge, held until waitrequest is seen low
  task automatic bus(input bit wr, input [5:0] a, input [31:0] d, output [31:0] q, output e);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 16)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 16)
    begin
      chk(1'b1, 1'b0, "bus timeout");
      summarize();
    end
    q = avs_readdata_o;
    e = avs_response_err_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // fit straps, pulse a reset for three cycles, wait for release and settling
  task automatic capture(input [23:0] f, input bit por);
    int n;
    n = 0;
    fit <= f;
    if (por)
      resetn_i <= 1'b0;
    else
      ext_resetn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    ext_resetn_i <= 1'b1;
    while (strap_sample_o !== 1'b0 && n < 16)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 16)
    begin
      chk(1'b1, 1'b0, "capture timeout");
      summarize();
    end
    repeat (8) @(posedge sys_clk_i);
  endtask
  function automatic logic [4:0] exp_fn(input int p);
    case (p) inside
      [3:7]:   return 5'(`FN_AUD_DIN + p - 3);
      [10:12]: return 5'(`FN_SS_PWR3 + p - 10);
      [13:17]: return 5'(`FN_PWR5 - (p - 13));
      18:      return `FN_HOST_SCL;
      [19:27]: return 5'(`FN_MICROPHONE_DETECT + p - 19);
      28:      return `FN_PWR6;
      [29:31]: return 5'(`FN_GPIO + p - 29);
      default: return `FN_NONE;
    endcase
  endfunction
  // ************************************************************
  // scenarios
  // ************************************************************
  // checks wait eight cycles, by which time the board shows inverted straps
  task automatic t_decode(input [2:0] l, input [5:0] p, input [5:0] m, input bit por);
    logic [31:0] q;
    logic        e;
    logic [5:0]  mask;
    logic        bad;
    mask = (l == 3'h5) ? 6'h3f : (6'h01 << l) - 6'h01;
    bad = (l == 3'h5);
    capture({m, p, `LVL_200K_DN, bad ? `LVL_10K_UP : `LVL_10K_DN, l, l}, por);
    chk(strap_sample_o, 1'b0, "strap phase");
    chk(port_disable_o, p & m, "port off");
    chk(ss_port_disable_o, p & m, "ss off");
    chk(fixed_port_mask_o, mask, "fixed mask");
    chk(charge_port_mask_o, mask, "charge mask");
    chk(mode_reserved_o, bad, "mode");
    if (bad)
      chk(pin_func_o, 145'h0, "reserved map");
    bus(1'b0, 6'h04, 32'h0000_0000, q, e);
    chk(q, {20'h0_0000, m, p}, "strap lines");
    bus(1'b0, `REG_LEVELS, 32'h0000_0000, q, e);
    chk(q, {20'h0_0000, `LVL_200K_DN, bad ? `LVL_10K_UP : `LVL_10K_DN, l, l}, "levels");
  endtask
  task automatic t_pinmap;
    logic [31:0] q;
    logic        e;
    for (int p = 3; p <= 31; p++)
      chk(pin_func_o[5*(p-3) +: 5], exp_fn(p), "pin map");
    bus(1'b0, `REG_CTRL, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0008, "capture count");
    bus(1'b1, 6'h10, 32'h0000_0005, q, e);
    bus(1'b1, 6'h14, {23'h00_0000, 1'b1, 3'h0, `FN_GPIO}, q, e);
    @(posedge sys_clk_i);
    chk(pin_func_o[14:10], `FN_GPIO, "override");
    bus(1'b0, 6'h14, 32'h0000_0000, q, e);
    chk(q, {23'h00_0000, 1'b1, 3'h0, `FN_AUD_BCLK}, "mux read");
    bus(1'b1, 6'h00, 32'h0000_0001, q, e);
    @(posedge sys_clk_i);
    chk(pin_func_o[14:10], `FN_AUD_BCLK, "override cleared");
    bus(1'b0, 6'h20, 32'h0000_0000, q, e);
    chk({e, q}, {1'b1, 32'h0000_0000}, "unmapped");
  endtask
  initial
  begin
    t_decode(3'h4, 6'h3f, 6'h15, 1'b1);
    for (int l = 0; l < 6; l++)
      t_decode(3'(l), 6'h2d ^ 6'(l), 6'h1b + 6'(l), 1'b0);
    t_decode(3'h2, 6'h3f, 6'h3f, 1'b0);
    t_pinmap();
    summarize();
  end
endmodule
